// ==== core/spsel_consts.svh ====
`ifndef SPSEL_CONSTS_SVH
`define SPSEL_CONSTS_SVH

// register addresses on the control port
`define SPSEL_ADDR_SEL_A 7'h26
`define SPSEL_ADDR_SEL_B 7'h27
`define SPSEL_ADDR_SEL_C 7'h28

// field positions within the 9-bit registers
`define SPSEL_LO_MSB 3
`define SPSEL_LO_LSB 0
`define SPSEL_HI_MSB 7
`define SPSEL_HI_LSB 4
`define SPSEL_CFG_BIT 8

// reset values of the selection fields
`define SPSEL_RST_PIN2 4'h1
`define SPSEL_RST_PIN3 4'h2
`define SPSEL_RST_PIN4 4'h3
`define SPSEL_RST_PIN5 4'h4
`define SPSEL_RST_PIN6 4'h5
`define SPSEL_RST_FILL 1'h0
`define SPSEL_RST_BYPASS 1'h0

// selection codes that turn a pin into a receiver input
`define SPSEL_CODE_CMOS_IN 4'hE
`define SPSEL_CODE_CMP_IN 4'hF

// pins of the output group: index 0 is pin two
`define SPSEL_NUM_PINS 5
`define SPSEL_FIRST_IN_PIN 1
`define SPSEL_NUM_IN_PINS 3

`endif

// ==== core/spsel_pkg.sv ====
package spsel_pkg;

	// receiver status sources, listed by selection code
	typedef struct packed {
		logic intN;
		logic validity;
		logic user;
		logic channelStatus;
		logic parity;
		logic subframeClock;
		logic blockStartMarker;
		logic unlock;
		logic channelStatusUpdated;
		logic invalid;
		logic zeroDetectFlag;
		logic compressedPayloadFlag;
		logic copyPermitFlag;
		logic emphasisFlag;
	} spsel_status_t;

	typedef struct packed {
		logic write;
		logic [6:0] addr;
		logic [8:0] data;
	} spsel_reg_req_t;

	typedef struct packed {
		logic transmissionErrorFlag;
		logic invalidFlag;
		logic transErrMasked;
		logic invalidMasked;
	} spsel_err_t;

endpackage

// ==== core/spsel_status_pin_select.sv ====
// Operation
// - a four-bit selection code 0000..1101 routes one receiver status signal or flag to its pin.
// - codes 1110 and 1111 turn pins three, four and five into receiver inputs, CMOS buffer or comparator.
// - with fill select 0, a masked error flag that is set makes the last valid sample repeat.
// - with fill select 1, a masked error flag that is set makes the output samples all zero.
// - the invalid flag is handled automatically while the bypass bit is 0 and ignored when it is 1.
// - register 26h holds the fill select in bit 8 and the pin two source in bits 7:4, reset 0001.
// - register 27h holds the bypass in bit 8, pin three source in 3:0 (0010) and pin four in 7:4 (0011).
`timescale 1ns/1ps
`include "spsel_consts.svh"

module spsel_status_pin_select #(
	parameter int SAMPLE_WIDTH = 24
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire spsel_pkg::spsel_reg_req_t regReq,
	output logic [8:0] regReadData,
	input wire spsel_pkg::spsel_status_t status,
	input wire spsel_pkg::spsel_err_t errFlags,
	input wire logic [SAMPLE_WIDTH-1:0] sampleIn,
	input wire logic sampleInValid,
	output logic [SAMPLE_WIDTH-1:0] sampleOut,
	output logic sampleOutValid,
	output logic [`SPSEL_NUM_PINS-1:0] pinOut,
	output logic [`SPSEL_NUM_PINS-1:0] pinOeN,
	input wire logic [`SPSEL_NUM_IN_PINS-1:0] pinIn,
	output logic [`SPSEL_NUM_IN_PINS-1:0] rxInData,
	output logic [`SPSEL_NUM_IN_PINS-1:0] rxInEnable,
	output logic [`SPSEL_NUM_IN_PINS-1:0] rxInComparator
);

	typedef struct packed {
		logic [3:0] pinTwoSource;
		logic errorSampleFillSelect;
		logic [3:0] pinThreeSource;
		logic [3:0] pinFourSource;
		logic invalidHandlingBypass;
		logic [3:0] pinFiveSource;
		logic [3:0] pinSixSource;
		logic [8:0] readData;
		logic [`SPSEL_NUM_PINS-1:0] pinOut;
		logic [`SPSEL_NUM_PINS-1:0] pinOeN;
		logic [`SPSEL_NUM_IN_PINS-1:0] syncFirst;
		logic [`SPSEL_NUM_IN_PINS-1:0] syncSecond;
		logic [`SPSEL_NUM_IN_PINS-1:0] rxInData;
		logic [`SPSEL_NUM_IN_PINS-1:0] rxInEnable;
		logic [`SPSEL_NUM_IN_PINS-1:0] rxInComparator;
		logic [SAMPLE_WIDTH-1:0] lastValid;
		logic [SAMPLE_WIDTH-1:0] sampleOut;
		logic sampleOutValid;
	} spsel_state_t;

	spsel_state_t state_q;
	spsel_state_t state_d;
	logic [`SPSEL_NUM_PINS-1:0][3:0] pinSource;
	logic transErrActive;
	logic invalidActive;
	logic errorActive;

	// status mux used by every pin
	function automatic logic spsel_pick(input logic [3:0] code, input spsel_pkg::spsel_status_t s);
		logic v;
		v = 1'h0;
		case (code)
			4'h0: v = s.intN;
			4'h1: v = s.validity;
			4'h2: v = s.user;
			4'h3: v = s.channelStatus;
			4'h4: v = s.parity;
			4'h5: v = s.subframeClock;
			4'h6: v = s.blockStartMarker;
			4'h7: v = s.unlock;
			4'h8: v = s.channelStatusUpdated;
			4'h9: v = s.invalid;
			4'hA: v = s.zeroDetectFlag;
			4'hB: v = s.compressedPayloadFlag;
			4'hC: v = s.copyPermitFlag;
			4'hD: v = s.emphasisFlag;
			// input codes and reserved codes drive low
			default: v = 1'h0;
		endcase
		return v;
	endfunction

	function automatic logic spsel_is_input(input logic [3:0] code);
		return (code == `SPSEL_CODE_CMOS_IN) || (code == `SPSEL_CODE_CMP_IN);
	endfunction

	assign pinSource[0] = state_q.pinTwoSource;
	assign pinSource[1] = state_q.pinThreeSource;
	assign pinSource[2] = state_q.pinFourSource;
	assign pinSource[3] = state_q.pinFiveSource;
	assign pinSource[4] = state_q.pinSixSource;

	// masked transmission errors always count; masked invalid counts only while bypass is 0
	assign transErrActive = errFlags.transmissionErrorFlag && errFlags.transErrMasked;
	assign invalidActive = errFlags.invalidFlag && errFlags.invalidMasked && !state_q.invalidHandlingBypass;
	assign errorActive = transErrActive || invalidActive;

	always_comb begin
		state_d = state_q;
		// register writes
		if (regReq.write) begin
			case (regReq.addr)
				`SPSEL_ADDR_SEL_A: begin
					state_d.pinTwoSource = regReq.data[`SPSEL_HI_MSB:`SPSEL_HI_LSB];
					state_d.errorSampleFillSelect = regReq.data[`SPSEL_CFG_BIT];
				end
				`SPSEL_ADDR_SEL_B: begin
					state_d.pinThreeSource = regReq.data[`SPSEL_LO_MSB:`SPSEL_LO_LSB];
					state_d.pinFourSource = regReq.data[`SPSEL_HI_MSB:`SPSEL_HI_LSB];
					state_d.invalidHandlingBypass = regReq.data[`SPSEL_CFG_BIT];
				end
				`SPSEL_ADDR_SEL_C: begin
					state_d.pinFiveSource = regReq.data[`SPSEL_LO_MSB:`SPSEL_LO_LSB];
					state_d.pinSixSource = regReq.data[`SPSEL_HI_MSB:`SPSEL_HI_LSB];
				end
				default: begin
					// unmapped writes dropped
				end
			endcase
		end
		// readback shows the stored fields; unmapped reads zero
		state_d.readData = 9'h000;
		case (regReq.addr)
			`SPSEL_ADDR_SEL_A: begin
				state_d.readData[`SPSEL_CFG_BIT] = state_q.errorSampleFillSelect;
				state_d.readData[`SPSEL_HI_MSB:`SPSEL_HI_LSB] = state_q.pinTwoSource;
			end
			`SPSEL_ADDR_SEL_B: begin
				state_d.readData[`SPSEL_CFG_BIT] = state_q.invalidHandlingBypass;
				state_d.readData[`SPSEL_HI_MSB:`SPSEL_HI_LSB] = state_q.pinFourSource;
				state_d.readData[`SPSEL_LO_MSB:`SPSEL_LO_LSB] = state_q.pinThreeSource;
			end
			`SPSEL_ADDR_SEL_C: begin
				state_d.readData[`SPSEL_HI_MSB:`SPSEL_HI_LSB] = state_q.pinSixSource;
				state_d.readData[`SPSEL_LO_MSB:`SPSEL_LO_LSB] = state_q.pinFiveSource;
			end
			default: begin
			end
		endcase
		// pin drive
		for (int i = 0; i < `SPSEL_NUM_PINS; i++) begin
			state_d.pinOut[i] = spsel_pick(pinSource[i], status);
			state_d.pinOeN[i] = 1'h0;
		end
		// input-capable pins; other pins keep driving low on 1110/1111
		for (int j = 0; j < `SPSEL_NUM_IN_PINS; j++) begin
			if (spsel_is_input(pinSource[j + `SPSEL_FIRST_IN_PIN])) begin
				state_d.pinOeN[j + `SPSEL_FIRST_IN_PIN] = 1'h1;
				state_d.pinOut[j + `SPSEL_FIRST_IN_PIN] = 1'h0;
				state_d.rxInEnable[j] = 1'h1;
				state_d.rxInComparator[j] = pinSource[j + `SPSEL_FIRST_IN_PIN] == `SPSEL_CODE_CMP_IN;
				state_d.rxInData[j] = state_q.syncSecond[j];
			end else begin
				state_d.rxInEnable[j] = 1'h0;
				state_d.rxInComparator[j] = 1'h0;
				state_d.rxInData[j] = 1'h0;
			end
		end
		if (spsel_is_input(state_q.pinTwoSource)) begin
			state_d.pinOut[0] = 1'h0;
		end
		if (spsel_is_input(state_q.pinSixSource)) begin
			state_d.pinOut[`SPSEL_NUM_PINS-1] = 1'h0;
		end
		// pin levels are asynchronous, two flops before use
		state_d.syncFirst = pinIn;
		state_d.syncSecond = state_q.syncFirst;
		// sample path
		state_d.sampleOutValid = sampleInValid;
		if (sampleInValid) begin
			if (errorActive) begin
				if (state_q.errorSampleFillSelect) begin
					state_d.sampleOut = '0;
				end else begin
					state_d.sampleOut = state_q.lastValid;
				end
			end else begin
				state_d.sampleOut = sampleIn;
				state_d.lastValid = sampleIn;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// selections come up at their defaults
			state_q <= '0;
			state_q.pinTwoSource <= `SPSEL_RST_PIN2;
			state_q.errorSampleFillSelect <= `SPSEL_RST_FILL;
			state_q.pinThreeSource <= `SPSEL_RST_PIN3;
			state_q.pinFourSource <= `SPSEL_RST_PIN4;
			state_q.invalidHandlingBypass <= `SPSEL_RST_BYPASS;
			state_q.pinFiveSource <= `SPSEL_RST_PIN5;
			state_q.pinSixSource <= `SPSEL_RST_PIN6;
		end else begin
			state_q <= state_d;
		end
	end

	assign regReadData = state_q.readData;
	assign sampleOut = state_q.sampleOut;
	assign sampleOutValid = state_q.sampleOutValid;
	assign pinOut = state_q.pinOut;
	assign pinOeN = state_q.pinOeN;
	assign rxInData = state_q.rxInData;
	assign rxInEnable = state_q.rxInEnable;
	assign rxInComparator = state_q.rxInComparator;

endmodule // spsel_status_pin_select

// ==== bench/spsel_board.sv ====
`timescale 1ns/1ps
module spsel_board (
	input logic [4:0] pinOut,
	input logic [4:0] pinOeN,
	input logic [2:0] drive,
	output logic [2:0] pinIn
);
	// device wins the wire while it drives
	assign pinIn = (pinOeN[3:1] & drive) | (~pinOeN[3:1] & pinOut[3:1]);
endmodule // spsel_board

// ==== bench/spsel_pin_assertions.sv ====
`timescale 1ns/1ps
module spsel_pin_assertions #(parameter int SAMPLE_WIDTH = 24) (
	input logic clk,
	input logic reset_n,
	input spsel_pkg::spsel_reg_req_t regReq,
	input logic [8:0] regReadData,
	input spsel_pkg::spsel_status_t status,
	input spsel_pkg::spsel_err_t errFlags,
	input logic [SAMPLE_WIDTH-1:0] sampleIn,
	input logic sampleInValid,
	input logic [SAMPLE_WIDTH-1:0] sampleOut,
	input logic sampleOutValid,
	input logic [4:0] pinOut,
	input logic [4:0] pinOeN,
	input logic [2:0] rxInEnable,
	input logic [2:0] rxInComparator
);
	logic [3:0] sel_q [5];
	logic fill_q;
	logic byp_q;
	logic [SAMPLE_WIDTH-1:0] last_q;
	logic err;
	assign err = errFlags.transmissionErrorFlag & errFlags.transErrMasked
		| errFlags.invalidFlag & errFlags.invalidMasked & !byp_q;
	// shadow of the stored fields, updated at the write edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_q <= '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
			fill_q <= 1'b0;
			byp_q <= 1'b0;
			last_q <= '0;
		end else begin
			if (regReq.write && regReq.addr == 7'h26) {fill_q, sel_q[0]} <= regReq.data[8:4];
			if (regReq.write && regReq.addr == 7'h27) {byp_q, sel_q[2], sel_q[1]} <= regReq.data;
			if (regReq.write && regReq.addr == 7'h28) {sel_q[4], sel_q[3]} <= regReq.data[7:0];
			if (sampleInValid && !err) last_q <= sampleIn;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	for (genvar i = 0; i < 5; i++) begin : g_route
		AST_PIN_ROUTE: assert property ($past(reset_n) && $past(sel_q[i]) < 4'hE
			|-> pinOut[i] == $past(status[13 - sel_q[i]]) && !pinOeN[i]) else $error("pin route wrong");
	end
	for (genvar i = 1; i < 4; i++) begin : g_in
		AST_IN_MODE: assert property ($past(reset_n) && $past(sel_q[i]) >= 4'hE |-> pinOeN[i]
			&& rxInEnable[i-1] && rxInComparator[i-1] == $past(sel_q[i][0])) else $error("input mode wrong");
	end
	for (genvar i = 0; i < 5; i += 4) begin : g_rsv
		AST_RESERVED: assert property ($past(reset_n) && $past(sel_q[i]) >= 4'hE
			|-> !pinOut[i] && !pinOeN[i]) else $error("reserved code not low");
	end
	AST_FILL_HOLD: assert property (sampleInValid && err && !fill_q
		|=> sampleOutValid && sampleOut == $past(last_q)) else $error("hold fill wrong");
	AST_FILL_ZERO: assert property (sampleInValid && err && fill_q
		|=> sampleOutValid && sampleOut == '0) else $error("zero fill wrong");
	AST_BYPASS: assert property (sampleInValid && byp_q && errFlags.invalidFlag && errFlags.invalidMasked
		&& !(errFlags.transmissionErrorFlag && errFlags.transErrMasked)
		|=> sampleOut == $past(sampleIn)) else $error("bypass sample wrong");
	AST_READ_A: assert property ($past(reset_n) && $past(regReq.addr) == 7'h26
		|-> regReadData == $past({fill_q, sel_q[0], 4'h0})) else $error("readback 26h wrong");
	AST_READ_B: assert property ($past(reset_n) && $past(regReq.addr) == 7'h27
		|-> regReadData == $past({byp_q, sel_q[2], sel_q[1]})) else $error("readback 27h wrong");
	cover property (sampleInValid && err && fill_q);
	cover property (sampleInValid && byp_q);
	cover property (rxInComparator[0]);
	cover property (sampleInValid && err && !fill_q);
endmodule // spsel_pin_assertions
bind spsel_status_pin_select spsel_pin_assertions #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) chk (
	.clk(clk),
	.reset_n(reset_n),
	.regReq(regReq),
	.regReadData(regReadData),
	.status(status),
	.errFlags(errFlags),
	.sampleIn(sampleIn),
	.sampleInValid(sampleInValid),
	.sampleOut(sampleOut),
	.sampleOutValid(sampleOutValid),
	.pinOut(pinOut),
	.pinOeN(pinOeN),
	.rxInEnable(rxInEnable),
	.rxInComparator(rxInComparator)
);

// ==== bench/spsel_testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("Error %s exp %h got %h", nm, e, g); end end
module testbench;
	logic clk, reset_n, sampleInValid, sampleOutValid;
	spsel_pkg::spsel_reg_req_t regReq;
	spsel_pkg::spsel_status_t status;
	spsel_pkg::spsel_err_t errFlags;
	logic [8:0] regReadData;
	logic [23:0] sampleIn, sampleOut;
	logic [4:0] pinOut, pinOeN;
	logic [2:0] pinIn, rxInData, rxInEnable, rxInComparator, drive;
	int fails = 0;
	int n_compared = 0;
	spsel_status_pin_select dut (
		.clk(clk),
		.reset_n(reset_n),
		.regReq(regReq),
		.regReadData(regReadData),
		.status(status),
		.errFlags(errFlags),
		.sampleIn(sampleIn),
		.sampleInValid(sampleInValid),
		.sampleOut(sampleOut),
		.sampleOutValid(sampleOutValid),
		.pinOut(pinOut),
		.pinOeN(pinOeN),
		.pinIn(pinIn),
		.rxInData(rxInData),
		.rxInEnable(rxInEnable),
		.rxInComparator(rxInComparator)
	);
	spsel_board board(.pinOut(pinOut), .pinOeN(pinOeN), .drive(drive), .pinIn(pinIn));
	always #4 clk = ~clk;
	task wrap_up();
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [6:0] a, input logic [8:0] d);
		@(posedge clk) regReq <= {1'b1, a, d};
		@(posedge clk) regReq.write <= 1'b0;
	endtask
	task rd(input logic [6:0] a, input logic [8:0] e);
		@(posedge clk) regReq <= {1'b0, a, 9'h000};
		repeat (2) @(posedge clk);
		#1 `CHK("readback", e, regReadData)
	endtask
	task smp(input logic [23:0] d, input logic [3:0] e, input logic [23:0] x);
		@(posedge clk) sampleIn <= d;
		sampleInValid <= 1'b1;
		errFlags <= e;
		@(posedge clk) sampleInValid <= 1'b0;
		#1 `CHK("sample", x, sampleOut)
		`CHK("sample valid", 1'b1, sampleOutValid)
	endtask
	task t_regs();
		rd(7'h26, 9'h010);
		rd(7'h27, 9'h032);
		rd(7'h28, 9'h054);
		// unmapped place reads zero
		rd(7'h2A, 9'h000);
	endtask
	task t_route();
		logic [4:0] hi;
		for (int c = 0; c < 14; c++) begin
			hi = {c == 5, c == 4, c == 3, c == 2, 1'h1};
			wr(7'h26, {1'b0, c[3:0], 4'h0});
			@(posedge clk) status <= 14'h2000 >> c;
			repeat (2) @(posedge clk);
			#1 `CHK("pins high", hi, pinOut)
			@(posedge clk) status <= '0;
			repeat (2) @(posedge clk);
			#1 `CHK("pins low", 5'h00, pinOut)
		end
	endtask
	task t_input();
		wr(7'h27, 9'h1EF);
		@(posedge clk) drive <= 3'b011;
		repeat (5) @(posedge clk);
		#1 `CHK("enables", 5'b00110, pinOeN)
		`CHK("comparator", 3'b001, rxInComparator)
		`CHK("input data", 3'b011, rxInData)
		`CHK("rx enables", 3'h3, rxInEnable)
		rd(7'h27, 9'h1EF);
		wr(7'h26, 9'h0F0);
		wr(7'h28, 9'h0E4);
		@(posedge clk) status <= '1;
		repeat (2) @(posedge clk);
		#1 `CHK("reserved pin", 2'b00, {pinOut[0], pinOeN[0]})
		`CHK("reserved pin six", 2'h0, {pinOut[4], pinOeN[4]})
	endtask
	task t_reset();
		@(posedge clk) reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(7'h26, 9'h010);
		rd(7'h27, 9'h032);
		rd(7'h28, 9'h054);
		`CHK("oe after reset", 5'h00, pinOeN)
	endtask
	task t_fill();
		smp(24'hA5A5A5, 4'h0, 24'hA5A5A5);
		// bypass set, invalid flag passes through
		smp(24'h123456, 4'h5, 24'h123456);
		wr(7'h27, 9'h032);
		smp(24'h777777, 4'h5, 24'h123456);
		wr(7'h26, 9'h110);
		rd(7'h26, 9'h110);
		smp(24'h888888, 4'hA, 24'h000000);
		smp(24'h99999A, 4'hA, 24'h000000);
	endtask
	initial begin
		{clk, reset_n, sampleInValid, regReq, status, errFlags, sampleIn, drive} = '0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_route();
		t_input();
		t_fill();
		t_reset();
		wrap_up();
	end
	// hang guard well past the expected run
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		wrap_up();
	end
endmodule // testbench
